// >>> verilog/rxafc_defs.svh
`ifndef RXAFC_DEFS_SVH
`define RXAFC_DEFS_SVH
// Register byte offsets
`define RA_OPMODE   8'h00
`define RA_CTRL     8'h04
`define RA_BW       8'h08
`define RA_DETECT   8'h0C
`define RA_FRF      8'h10
`define RA_AFCVAL   8'h14
`define RA_TIMEOUT  8'h18
`define RA_FLAGS    8'h1C
// Control register bits
`define CB_AUTO     0
`define CB_ACLR     1
`define CB_START    2
`define CB_LOWIDX   3
`define CB_PREON    4
`define CB_RESTART  5
`define CB_TSTART   6
`define CB_TBUSY    7
// Flag register bits
`define FB_PRE      0
`define FB_TMO      1
`define FB_LVL      2
`define FB_AFC      3
// Reset values
`define RST_FRF     24'h6C8000
`define RST_RXBW    5'h05
`define RST_AFCBW   5'h0B
`define RST_TOL     5'h0A
`define RST_PLEN    2'h1
// Timing
`define CLK_MHZ     20
`define TEMP_MAX_US 100
`define TEMP_CYC    ((`TEMP_MAX_US * `CLK_MHZ) - 1)
`define SEQ_STEP_US 2
`define SEQ_CYC     (`SEQ_STEP_US * `CLK_MHZ)
`define FEI_BITS    4
`define TMO_BITS    16
`define LOWIDX_HZ   488
`define FSTEP_HZ    61
`define LOWIDX_LSB  (`LOWIDX_HZ / `FSTEP_HZ)
`endif

// >>> verilog/rxafc_pkg.sv
package rxafc_pkg;
   typedef enum logic [2:0] {
      RXAFC_SLEEP, RXAFC_STBY, RXAFC_FS, RXAFC_TX, RXAFC_RX, RXAFC_LISTEN
   } rxafc_mode_e;
   typedef enum logic [1:0] {AFC_IDLE, AFC_WAIT, AFC_MEAS, AFC_APPLY} rxafc_afc_e;
endpackage : rxafc_pkg

// >>> verilog/rxafc_sync.sv
`timescale 1ns/1ps
module rxafc_sync
(
   input  wire logic clk,   // Clock
   input  wire logic rst,   // Async reset
   input  wire logic d,     // Asynchronous pin
   output logic      q      // Filtered level
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   // Three stages; accept a change once stages two and three agree
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         q    <= 1'b0;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            q <= s3_r;
      end
   end
endmodule : rxafc_sync

// >>> verilog/rxafc_tmr.sv
`timescale 1ns/1ps
`include "rxafc_defs.svh"
module rxafc_tmr
(
   input  wire logic       clk,      // Clock
   input  wire logic       rst,      // Async reset
   input  wire logic       clr,      // Restart timing
   input  wire logic       run,      // Count enable
   input  wire logic       bit_tick, // One pulse per bit
   input  wire logic [7:0] limit,    // Units of 16 bits, 0 = off
   output logic            expired   // Pulse on expiry
);
   logic [3:0] sub_r;
   logic [7:0] unit_r;

   // Sixteen bit periods per unit; a zero limit never fires
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sub_r   <= 4'h0;
         unit_r  <= 8'h00;
         expired <= 1'b0;
      end
      else
      begin
         expired <= 1'b0;
         if (clr)
         begin
            sub_r  <= 4'h0;
            unit_r <= 8'h00;
         end
         else if (run && bit_tick && limit != 8'h00 && unit_r != limit)
         begin
            sub_r <= sub_r + 4'h1;
            if (sub_r == 4'(`TMO_BITS - 1))
            begin
               unit_r <= unit_r + 8'h01;
               if (unit_r + 8'h01 == limit)
                  expired <= 1'b1;
            end
         end
      end
   end
endmodule : rxafc_tmr

// >>> verilog/rxafc_top.sv
// What this block does
// R01 - Correction measured only while preamble received
// R02 - Subtract correction from carrier frequency word
// R03 - Auto enable launches correction on receiver entry
// R04 - Manual start bit launches one correction
// R05 - Auto-clear discards previous correction first
// R06 - Use correction bandwidth during correction phase
// R07 - Low-index adds offset code times 488 Hz
// R08 - Software keeps offset above DC cut
// R09 - Software offsets carrier for wide-band use
// R10 - Match length selects 1..3 bytes; 11 reserved
// R11 - Software sets tolerance 10, two bytes
// R12 - Preamble found raises flag and pin
// R13 - Processor may restart receiver on preamble
// R14 - Temperature only in standby or synth mode
// R15 - Temperature done and busy cleared within 100us
// R16 - Temperature code falls one per degree
// R17 - Start timeout fires without signal level
// R18 - Post-level timeout fires after signal level
// R19 - Mode field selects mode and enabled blocks
// R20 - Periodic listen overrides mode field
// R21 - Sequencer orders wake-up unless bypassed
// R22 - Error estimate takes four bits, signed
// R23 - Leaving receive resets both timeout counters
// R24 - Timeout flag held, raised once per sequence
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "rxafc_defs.svh"
module rxafc_top
   import rxafc_pkg::*;
(
   input  wire logic        ref_clk,       // 20 MHz clock
   input  wire logic        rst,           // Async reset, high
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB write
   input  wire logic [7:0]  paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic [31:0]      prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error
   input  wire logic        bit_tick,      // One pulse per bit period
   input  wire logic        rx_data,       // Demodulated bit
   input  wire logic        level_pin,     // Signal level comparator
   input  wire logic [15:0] fei_in,        // Signed error estimate
   input  wire logic [7:0]  temp_adc,      // Sensor conversion
   output logic [23:0]      carrier_word,  // Operating frequency
   output logic [4:0]       chan_bw,       // Active filter bandwidth
   output logic [3:0]       blk_en,        // {rx,tx,synth,osc}
   output logic             listen_act,    // Listen mode active
   output logic             fei_run,       // Estimator running
   output logic             adc_temp_sel,  // Converter on sensor
   output logic             preamble_pin,  // Preamble found pin
   output logic             timeout_pin    // Timeout pin
);
   logic [2:0]  mode_r;
   logic        listen_r;
   logic        bypass_r;
   logic        auto_r;
   logic        aclr_r;
   logic        lowidx_r;
   logic        preon_r;
   logic [4:0]  rxbw_r;
   logic [4:0]  afcbw_r;
   logic [2:0]  dccut_r;
   logic [7:0]  lowoff_r;
   logic [1:0]  plen_r;
   logic [4:0]  tol_r;
   logic [7:0]  to_start_r;
   logic [7:0]  to_post_r;
   logic [3:0]  flags_r;
   logic [15:0] afcval_r;
   logic [15:0] fei_r;
   logic [7:0]  temp_r;
   logic        wr;
   logic        rd_ok;
   logic        start_wr;
   logic        restart_wr;
   logic        tstart_wr;
   logic [31:0] rdat;
   rxafc_mode_e cur_r;
   rxafc_mode_e tgt;
   logic [5:0]  seq_r;
   logic        rx_act;
   logic        rx_act_d;
   logic        rx_entry;
   logic        level;
   logic        lvl_seen_r;
   logic        tmo_done_r;
   logic        exp_start;
   logic        exp_post;
   logic        pre_hit;
   rxafc_afc_e  afc_st;
   logic [1:0]  fei_cnt_r;
   logic [15:0] corr;
   logic        tbusy_r;
   logic [10:0] tcnt_r;
   logic        last_r;
   logic [4:0]  run_r;
   logic [4:0]  err_r;
   logic [4:0]  need;

   assign wr = psel && penable && pready && pwrite;
   assign start_wr = wr && paddr == `RA_CTRL && pwdata[`CB_START];
   assign restart_wr = wr && paddr == `RA_CTRL && pwdata[`CB_RESTART];
   assign tstart_wr = wr && paddr == `RA_CTRL && pwdata[`CB_TSTART];

   // Read mux, if chain per address
   always_comb
   begin
      rdat = 32'h0000_0000;
      rd_ok = 1'b1;
      if (paddr == `RA_OPMODE)
         rdat = {21'h0, 3'(cur_r), bypass_r, listen_r, 3'h0, mode_r};
      else if (paddr == `RA_CTRL)
         rdat = {24'h0, tbusy_r, 2'h0, preon_r, lowidx_r,
                 afc_st != AFC_IDLE, aclr_r, auto_r};
      else if (paddr == `RA_BW)
         rdat = {16'h0, dccut_r, afcbw_r, 3'h0, rxbw_r};
      else if (paddr == `RA_DETECT)
         rdat = {17'h0, tol_r, plen_r, lowoff_r};
      else if (paddr == `RA_FRF)
         rdat = {8'h00, carrier_word};
      else if (paddr == `RA_AFCVAL)
         rdat = {fei_r, afcval_r}; // R22
      else if (paddr == `RA_TIMEOUT)
         rdat = {16'h0, to_post_r, to_start_r};
      else if (paddr == `RA_FLAGS)
         rdat = {16'h0, temp_r, 4'h0, flags_r};
      else
         rd_ok = 1'b0;
   end

   // One wait state so that read data comes from a flop
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && penable && !pready;
         prdata  <= (psel && !pwrite) ? rdat : 32'h0000_0000;
         pslverr <= psel && penable && !pready && !rd_ok;
      end
   end

   // Configuration registers
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         mode_r <= 3'h1;
         listen_r <= 1'b0;
         bypass_r <= 1'b0;
         auto_r <= 1'b0;
         aclr_r <= 1'b0;
         lowidx_r <= 1'b0;
         preon_r <= 1'b1;
         rxbw_r <= `RST_RXBW;
         afcbw_r <= `RST_AFCBW;
         dccut_r <= 3'h4;
         lowoff_r <= 8'h00;
         plen_r <= `RST_PLEN;
         tol_r <= `RST_TOL;
         to_start_r <= 8'h00;
         to_post_r <= 8'h00;
      end
      else if (wr)
      begin
         if (paddr == `RA_OPMODE)
         begin
            mode_r <= pwdata[2:0];
            listen_r <= pwdata[6];
            bypass_r <= pwdata[7];
         end
         else if (paddr == `RA_CTRL)
         begin
            auto_r <= pwdata[`CB_AUTO];
            aclr_r <= pwdata[`CB_ACLR];
            lowidx_r <= pwdata[`CB_LOWIDX];
            preon_r <= pwdata[`CB_PREON];
         end
         else if (paddr == `RA_BW)
         begin
            rxbw_r <= pwdata[4:0];
            afcbw_r <= pwdata[12:8];
            dccut_r <= pwdata[15:13];
         end
         else if (paddr == `RA_DETECT)
         begin
            lowoff_r <= pwdata[7:0];
            plen_r <= pwdata[9:8];
            tol_r <= pwdata[14:10];
         end
         else if (paddr == `RA_TIMEOUT)
         begin
            to_start_r <= pwdata[7:0];
            to_post_r <= pwdata[15:8];
         end
      end
   end

   // Requested mode; listen wins over the mode field
   always_comb
   begin
      if (listen_r)
         tgt = RXAFC_LISTEN; // R20
      else if (mode_r == 3'h0)
         tgt = RXAFC_SLEEP; // R19
      else if (mode_r == 3'h1)
         tgt = RXAFC_STBY;
      else if (mode_r == 3'h2)
         tgt = RXAFC_FS;
      else if (mode_r == 3'h3)
         tgt = RXAFC_TX;
      else if (mode_r == 3'h4)
         tgt = RXAFC_RX;
      else
         tgt = cur_r; // Undefined codes keep the present mode
   end

   // Sequencer: wake upward one stage per step, fall directly
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cur_r <= RXAFC_STBY;
         seq_r <= 6'h00;
      end
      else if (bypass_r || tgt == RXAFC_LISTEN)
      begin
         cur_r <= tgt; // R21
         seq_r <= 6'h00;
      end
      else if (cur_r != tgt)
      begin
         seq_r <= seq_r + 6'h01;
         if (seq_r == 6'(`SEQ_CYC - 1))
         begin
            seq_r <= 6'h00;
            if (cur_r == RXAFC_SLEEP || cur_r == RXAFC_LISTEN)
               cur_r <= (tgt == RXAFC_SLEEP) ? RXAFC_SLEEP : RXAFC_STBY; // R21
            else if (cur_r == RXAFC_STBY && tgt != RXAFC_SLEEP)
               cur_r <= RXAFC_FS;
            else
               cur_r <= tgt;
         end
      end
      else
         seq_r <= 6'h00;
   end

   assign rx_act = (cur_r == RXAFC_RX);
   assign rx_entry = (rx_act && !rx_act_d) || (rx_act && restart_wr);

   // Enabled blocks per applied mode; listen flag registered alongside
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         blk_en <= 4'h1;
         listen_act <= 1'b0;
         rx_act_d <= 1'b0;
      end
      else
      begin
         rx_act_d <= rx_act;
         listen_act <= (cur_r == RXAFC_LISTEN);
         case (cur_r)
            RXAFC_SLEEP: blk_en <= 4'h0; // R19
            RXAFC_STBY:  blk_en <= 4'h1;
            RXAFC_FS:    blk_en <= 4'h3;
            RXAFC_TX:    blk_en <= 4'h7;
            RXAFC_RX:    blk_en <= 4'hB;
            default:     blk_en <= 4'h1;
         endcase
      end
   end

   rxafc_sync u_lvl
   (
      .clk (ref_clk),
      .rst (rst),
      .d   (level_pin),
      .q   (level)
   );

   // Alternating-bit finder; mismatches up to the tolerance are forgiven
   assign need = (plen_r == 2'h0) ? 5'h08 : (plen_r == 2'h1) ? 5'h10 : 5'h18; // R10
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         last_r <= 1'b0;
         run_r <= 5'h00;
         err_r <= 5'h00;
         pre_hit <= 1'b0;
      end
      else
      begin
         pre_hit <= 1'b0;
         if (!preon_r || !rx_act || plen_r == 2'h3)
         begin
            run_r <= 5'h00;
            err_r <= 5'h00;
         end
         else if (bit_tick)
         begin
            last_r <= rx_data;
            if (rx_data != last_r || err_r < tol_r)
            begin
               err_r <= (rx_data != last_r) ? err_r : err_r + 5'h01;
               if (run_r + 5'h01 == need)
               begin
                  pre_hit <= 1'b1; // R12
                  run_r <= 5'h00;
                  err_r <= 5'h00;
               end
               else
                  run_r <= run_r + 5'h01;
            end
            else
            begin
               run_r <= 5'h00;
               err_r <= 5'h00;
            end
         end
      end
   end

   rxafc_tmr u_tmr_start
   (
      .clk      (ref_clk),
      .rst      (rst),
      .clr      (!rx_act || rx_entry), // R23
      .run      (!lvl_seen_r),
      .bit_tick (bit_tick),
      .limit    (to_start_r),
      .expired  (exp_start)
   );

   rxafc_tmr u_tmr_post
   (
      .clk      (ref_clk),
      .rst      (rst),
      .clr      (!rx_act || rx_entry), // R23
      .run      (lvl_seen_r),
      .bit_tick (bit_tick),
      .limit    (to_post_r),
      .expired  (exp_post)
   );

   // Sticky flags; a hardware set wins over a same-cycle software clear
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         flags_r <= 4'h0;
         lvl_seen_r <= 1'b0;
         tmo_done_r <= 1'b0;
         preamble_pin <= 1'b0;
         timeout_pin <= 1'b0;
      end
      else
      begin
         if (!rx_act || rx_entry)
         begin
            lvl_seen_r <= 1'b0;
            tmo_done_r <= 1'b0;
         end
         else
         begin
            if (level)
               lvl_seen_r <= 1'b1;
            if ((exp_start && !lvl_seen_r) || (exp_post && lvl_seen_r))
               tmo_done_r <= 1'b1; // R24
         end
         if (wr && paddr == `RA_FLAGS)
            flags_r <= flags_r & ~pwdata[3:0];
         if (rx_entry)
            flags_r[`FB_TMO] <= 1'b0; // R24
         if (pre_hit)
            flags_r[`FB_PRE] <= 1'b1; // R12
         if (level && rx_act)
            flags_r[`FB_LVL] <= 1'b1;
         if (exp_start && !lvl_seen_r && !tmo_done_r && !rx_entry)
            flags_r[`FB_TMO] <= 1'b1; // R17
         if (exp_post && lvl_seen_r && !tmo_done_r && !rx_entry)
            flags_r[`FB_TMO] <= 1'b1; // R18
         if (afc_st == AFC_APPLY)
            flags_r[`FB_AFC] <= 1'b1;
         preamble_pin <= flags_r[`FB_PRE] || pre_hit;
         timeout_pin <= flags_r[`FB_TMO];
      end
   end

   // Correction: estimate plus optional low-index offset in synth steps
   assign corr = fei_r + (lowidx_r ? 16'(lowoff_r * `LOWIDX_LSB) : 16'h0000); // R07

   // Correction sequence
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         afc_st <= AFC_IDLE;
         fei_cnt_r <= 2'h0;
         fei_r <= 16'h0000;
         afcval_r <= 16'h0000;
         carrier_word <= `RST_FRF;
         fei_run <= 1'b0;
         chan_bw <= `RST_RXBW;
      end
      else
      begin
         chan_bw <= (afc_st == AFC_MEAS) ? afcbw_r : rxbw_r; // R06
         fei_run <= (afc_st == AFC_MEAS);
         if (wr && paddr == `RA_FRF)
            carrier_word <= pwdata[23:0];
         case (afc_st)
            AFC_IDLE:
            begin
               if (auto_r && rx_entry) // R03
               begin
                  afc_st <= AFC_WAIT;
                  if (aclr_r) // R05
                  begin
                     carrier_word <= carrier_word + {{8{afcval_r[15]}}, afcval_r};
                     afcval_r <= 16'h0000;
                  end
               end
               else if (!auto_r && start_wr) // R04
                  afc_st <= AFC_WAIT;
            end
            AFC_WAIT:
            begin
               fei_cnt_r <= 2'h0;
               if (!rx_act)
                  afc_st <= AFC_IDLE;
               else if (pre_hit) // R01
                  afc_st <= AFC_MEAS;
            end
            AFC_MEAS:
            begin
               if (!rx_act)
                  afc_st <= AFC_IDLE;
               else if (bit_tick)
               begin
                  fei_cnt_r <= fei_cnt_r + 2'h1;
                  if (fei_cnt_r == 2'(`FEI_BITS - 1))
                  begin
                     fei_r <= fei_in; // R22
                     afc_st <= AFC_APPLY;
                  end
               end
            end
            AFC_APPLY:
            begin
               carrier_word <= carrier_word - {{8{corr[15]}}, corr}; // R02
               afcval_r <= afcval_r + corr;
               afc_st <= AFC_IDLE;
            end
            default: afc_st <= AFC_IDLE;
         endcase
      end
   end

   // Temperature: standby or synth only, fixed run under 100 us
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         tbusy_r <= 1'b0;
         tcnt_r <= 11'h000;
         temp_r <= 8'h00;
         adc_temp_sel <= 1'b0;
      end
      else
      begin
         adc_temp_sel <= tbusy_r;
         if (!tbusy_r)
         begin
            if (tstart_wr && (cur_r == RXAFC_STBY || cur_r == RXAFC_FS)) // R14
            begin
               tbusy_r <= 1'b1;
               tcnt_r <= 11'h000;
            end
         end
         else if (tcnt_r == 11'(`TEMP_CYC - 1))
         begin
            tbusy_r <= 1'b0; // R15
            temp_r <= 8'hFF - temp_adc; // R16
         end
         else
            tcnt_r <= tcnt_r + 11'h001;
      end
   end
endmodule : rxafc_top

// >>> verif/rxafc_props.sv
`timescale 1ns/1ps
module rxafc_props
(
   input wire logic        ref_clk,      // Clock
   input wire logic        rst,          // Reset
   input wire logic        psel,         // Select
   input wire logic        penable,      // Enable
   input wire logic [23:0] carrier_word, // Frequency
   input wire logic [3:0]  blk_en,       // Blocks
   input wire logic        bit_tick,     // Bit strobe
   input wire logic        fei_run,      // Measuring
   input wire logic        adc_temp_sel, // Sensor on
   input wire logic        preamble_pin, // Preamble
   input wire logic        timeout_pin   // Timeout
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [11:0] tmp_cnt_r;
   logic [2:0]  tick_cnt_r;
   // Run length of a measurement, bits seen while estimating
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
      begin
         tmp_cnt_r  <= 12'h0;
         tick_cnt_r <= 3'h0;
      end
      else
      begin
         tmp_cnt_r  <= adc_temp_sel ? tmp_cnt_r + 12'h1 : 12'h0;
         tick_cnt_r <= fei_run ? tick_cnt_r + {2'h0, bit_tick} : 3'h0;
      end
   chk_fei_preamble: assert property ($rose(fei_run) |-> ##[0:2] preamble_pin)
      else $error("estimate without preamble");
   chk_carrier_cause: assert property (!$stable(carrier_word) |-> $past(fei_run)
      || $past(fei_run, 2) || $past(fei_run, 3) || $past(psel && penable)
      || blk_en[3] != $past(blk_en[3]))
      else $error("carrier moved without cause");
   chk_temp_mode: assert property (adc_temp_sel |-> blk_en == 4'h1 || blk_en == 4'h3)
      else $error("sensor run outside standby or synth");
   chk_temp_len: assert property (tmp_cnt_r < 12'h7D0)
      else $error("sensor run too long");
   chk_fei_bits: assert property ($fell(fei_run) |-> tick_cnt_r == 3'h4)
      else $error("estimate not four bits");
   chk_tmo_hold: assert property (timeout_pin && blk_en[3] && $past(blk_en[3])
      && !(psel && penable) && !$past(psel && penable) |=> timeout_pin)
      else $error("timeout dropped by itself");
   chk_tmo_in_rx: assert property ($rose(timeout_pin) |-> $past(blk_en) == 4'hB)
      else $error("timeout outside receive");
   chk_tmo_stopped: assert property (!blk_en[3] && !timeout_pin |=> !timeout_pin)
      else $error("timer ran after receive");
   cov_corr: cover property ($fell(fei_run));
   cov_tmo: cover property ($rose(timeout_pin));
   cov_temp: cover property ($fell(adc_temp_sel));
endmodule : rxafc_props

// >>> verif/rxafc_radio.sv
`timescale 1ns/1ps
module rxafc_radio
(
   input  wire logic        ref_clk,   // Clock
   input  wire logic        rst,       // Reset
   input  wire logic        pre_on,    // Send preamble
   input  wire logic        lvl_on,    // Carrier present
   input  wire logic [15:0] fei_val,   // Error to report
   input  wire logic [7:0]  adc_val,   // Sensor code
   output logic             bit_tick,  // Bit strobe
   output logic             rx_data,   // Demodulated bit
   output logic             level_pin, // Comparator
   output logic [15:0]      fei_in,    // Error estimate
   output logic [7:0]       temp_adc   // Conversion
);
   logic [1:0] div_r;
   // Four clocks a bit keeps timeouts short; estimate is junk off preamble
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
      begin
         div_r     <= 2'h0;
         bit_tick  <= 1'b0;
         rx_data   <= 1'b1;
         level_pin <= 1'b0;
         fei_in    <= 16'h0;
         temp_adc  <= 8'h0;
      end
      else
      begin
         div_r     <= div_r + 2'h1;
         bit_tick  <= (div_r == 2'h3);
         if (bit_tick)
            rx_data <= pre_on ? ~rx_data : 1'b1;
         level_pin <= lvl_on;
         fei_in    <= pre_on ? fei_val : ~fei_in;
         temp_adc  <= adc_val;
      end
endmodule : rxafc_radio

// >>> verif/rxafc_top_tb.sv
`timescale 1ns/1ps
module rxafc_top_tb;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic        pre_on = 1'b0;
   logic        lvl_on = 1'b0;
   logic [15:0] fei_val = 16'h0;
   logic [7:0]  adc_val = 8'h0;
   logic [31:0] seed = 32'h9825;
   logic [31:0] prdata, rd, r;
   logic [23:0] carrier_word;
   logic [15:0] fei_in;
   logic [7:0]  temp_adc;
   logic [4:0]  chan_bw, cbw;
   logic [3:0]  blk_en;
   logic        pready, pslverr, er, bit_tick, rx_data, level_pin, listen_act;
   logic        fei_run, adc_temp_sel, preamble_pin, timeout_pin;
   logic [3:0]  blk [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hB};
   int          err_count = 0;
   int          checks = 0;
   int          n, c0, acc, cyc = 0;

   rxafc_top   dut_u (.*);
   rxafc_radio far_u (.*);

   // Clock and a free cycle count
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc++;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   // One transfer plus an idle edge, so no signal is set twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask : rdc

   task automatic final_report();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report

   // Run needs about 3400 cycles
   initial
   begin
      #1000000;
      err_count++;
      final_report();
   end

   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      cmp(carrier_word, 32'h6C8000);
      rdc(8'h00, 32'h101);
      rdc(8'h0C, 32'h2900);
      apb(1'b0, 8'h20, 32'h0);
      cmp(er, 1'b1);
      $display("test reset done");
      // Every basic mode, sequencer bypassed, then listen
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b1, 8'h00, 32'h80 | i);
         rdc(8'h00, 32'h80 | (i << 8) | i);
         cmp(blk_en, blk[i]);
      end
      apb(1'b1, 8'h00, 32'h41);
      rdc(8'h00, 32'h541);
      cmp(listen_act, 1'b1);
      // Sequenced wake into receive with a one-unit start timeout
      apb(1'b1, 8'h18, 32'h1);
      apb(1'b1, 8'h00, 32'h80);
      apb(1'b1, 8'h00, 32'h4);
      cmp(blk_en[3], 1'b0);
      repeat (126) @(posedge ref_clk);
      cmp(blk_en, 4'hB);
      cmp(timeout_pin, 1'b0);
      repeat (80) @(posedge ref_clk);
      rdc(8'h1C, 32'h2);
      repeat (100) @(posedge ref_clk);
      cmp(timeout_pin, 1'b1);
      apb(1'b1, 8'h1C, 32'h2);
      repeat (200) @(posedge ref_clk);
      cmp(timeout_pin, 1'b0);
      // Post-level timeout after a restart
      apb(1'b1, 8'h18, 32'h100);
      lvl_on <= 1'b1;
      apb(1'b1, 8'h04, 32'h30);
      cmp(timeout_pin, 1'b0);
      repeat (100) @(posedge ref_clk);
      cmp(timeout_pin, 1'b1);
      lvl_on <= 1'b0;
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h00, 32'h81);
      apb(1'b1, 8'h1C, 32'hF);
      $display("test modes and timeouts done");
      // Temperature in standby, polled until idle
      r = rnd();
      adc_val <= r[7:0];
      c0 = cyc;
      apb(1'b1, 8'h04, 32'h50);
      apb(1'b0, 8'h04, 32'h0);
      cmp(rd[7], 1'b1);
      do
         apb(1'b0, 8'h04, 32'h0);
      while (rd[7] === 1'b1 && cyc - c0 < 2100);
      cmp(cyc - c0 < 2010, 1'b1);
      apb(1'b0, 8'h1C, 32'h0);
      cmp(rd & 32'hFF00, {16'h0, 8'hFF - r[7:0], 8'h0});
      $display("test temperature done");
      // Manual low-index correction; offset kept above a zero DC cut
      r = rnd();
      cbw = r[20:16];
      fei_val <= {{6{r[9]}}, r[9:0]};
      apb(1'b1, 8'h08, {19'h0, cbw, 8'h05});
      apb(1'b1, 8'h0C, {16'h0, 8'h29, r[31:25], 1'b1});
      apb(1'b1, 8'h04, 32'h18);
      apb(1'b1, 8'h00, 32'h84);
      pre_on <= 1'b1;
      apb(1'b1, 8'h04, 32'h1C);
      acc = int'($signed(r[9:0])) + int'({r[31:25], 1'b1}) * 8;
      repeat (200)
      begin
         @(posedge ref_clk);
         if (fei_run === 1'b1)
            cmp(chan_bw, cbw);
      end
      cmp(carrier_word, (32'h6C8000 - acc) & 32'hFFFFFF);
      cmp(preamble_pin, 1'b1);
      // Automatic launch on restart, with and then without auto-clear
      for (int c = 1; c >= 0; c--)
      begin
         apb(1'b1, 8'h04, 32'h11 | (c << 1));
         apb(1'b1, 8'h04, 32'h31 | (c << 1));
         acc = c ? 0 : acc;
         acc = acc + int'($signed(r[9:0]));
         repeat (200) @(posedge ref_clk);
         cmp(carrier_word, (32'h6C8000 - acc) & 32'hFFFFFF);
      end
      rdc(8'h14, {fei_val, fei_val + fei_val});
      apb(1'b1, 8'h04, 32'h50);
      apb(1'b0, 8'h04, 32'h0);
      cmp(rd[7], 1'b0);
      // Wide-band use: no correction, carrier nudged by hand
      apb(1'b1, 8'h10, 32'h6C80A0);
      rdc(8'h10, 32'h6C80A0);
      $display("test correction done");
      final_report();
   end
endmodule : rxafc_top_tb

bind rxafc_top rxafc_props chk_u (.*);
